// [inc/ext_bus_pkg.sv]
/*
  Constants, types and timing figures shared by the external bus cycle sequencer.
  Assumes one 10 MHz clock and a half machine cycle derived from it by a divider.
*/
// Notes on behaviour
// - Multiplexed: drive address, pulse latch strobe, then withdraw address from bus.
// - Byte multiplexed: upper lane keeps driving A15..A8 for the whole access.
// - Segment address A17..A16 is never shared with data and always driven.
// - Multiplexed read: read strobe falls when the address is withdrawn and released.
// - Multiplexed read: capture data, then raise strobe; memory drives only meanwhile.
// - Multiplexed write: after address withdrawn, drive data, assert write strobe, end it.
// - Multiplexed write data stays on the bus until the next access starts.
// - Non-multiplexed: address held until next access, read strobe after fixed delay.
// - Non-multiplexed read: capture data, then remove read strobe.
// - Non-multiplexed write: drive data with write strobe, hold data until next cycle.
// - Programmed waits never lengthen on-chip memory accesses.
// - Zero to fifteen half-cycle waits per external access; reset gives fifteen.
// - Wait count is fifteen minus the four-bit field value.
// - Processor stalls while cycle-time waits run until the access completes.
// - Zero waits: multiplexed cycle three half cycles, non-multiplexed two.
// - Wait programming acts the same in every bus configuration.
// - One optional tri-state wait before the next address; reset inserts it.
// - After a read, next address waits until the tri-state wait elapses.
// - Processor does not stall during a tri-state wait.
// - Tri-state bit zero inserts one wait, one inserts none.
// - Multiplexed modes always add one implicit tri-state wait; the code adds it after reads only, never after writes.
package ext_bus_pkg;

  localparam int CLK_PERIOD_NS = 100;
  localparam int HALF_CYCLE_NS = 50;
  localparam int HALF_CYCLE_RAW = (HALF_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HALF_CYCLE_CLKS = (HALF_CYCLE_RAW < 1) ? 1 : HALF_CYCLE_RAW;
  localparam logic [3:0] TICK_LAST = 4'(HALF_CYCLE_CLKS - 1);

  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;
  localparam int SEG_HI = 17;
  localparam int SEG_LO = 16;
  localparam int LANE_HI_MSB = 15;
  localparam int LANE_HI_LSB = 8;
  localparam int LANE_LO_MSB = 7;

  localparam logic [3:0] WAIT_FIELD_NONE = 4'hF;
  localparam logic TRISTATE_INSERT = 1'b0;
  localparam logic [4:0] MUX_BASE_HALVES = 5'h03;
  localparam logic [4:0] NONMUX_BASE_HALVES = 5'h02;
  localparam logic [1:0] TRI_CNT_ZERO = 2'h0;
  localparam logic [1:0] TRI_CNT_ONE = 2'h1;

  typedef struct packed {
    logic mux_mode;
    logic byte_mode;
    logic tristate_wait_bit;
    logic [3:0] cycle_wait_field;
  } system_bus_config_s;

  localparam system_bus_config_s CFG_RESET = '{mux_mode: 1'b1, byte_mode: 1'b0,
    tristate_wait_bit: 1'b0, cycle_wait_field: 4'h0};

  typedef struct packed {
    logic write;
    logic internal;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } cpu_req_s;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ADDR = 5'h02,
    ST_HOLD = 5'h04,
    ST_STROBE = 5'h08,
    ST_TRI = 5'h10
  } seq_state_e;

endpackage

// [core/half_cycle_tick.sv]
/*
  Divider giving a one-cycle enable pulse per half machine cycle.
  Assumes the single system clock and synchronous reset.
*/
`timescale 1ns/1ns
module half_cycle_tick
  import ext_bus_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  output logic o_tick
);

  logic [3:0] cnt_r;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      cnt_r <= 4'h0;
      o_tick <= 1'b0;
    end
    else if (cnt_r == TICK_LAST)
    begin
      cnt_r <= 4'h0;
      o_tick <= 1'b1;
    end
    else
    begin
      cnt_r <= cnt_r + 4'h1;
      o_tick <= 1'b0;
    end
  end

endmodule // half_cycle_tick

// [core/wait_counter.sv]
/*
  Down counter of memory cycle time wait states, one step per tick.
  Assumes the caller loads it on entry to the strobe phase.
*/
`timescale 1ns/1ns
module wait_counter
  import ext_bus_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_load,
  input wire logic [3:0] i_count,
  input wire logic i_tick,
  output logic o_done
);

  logic [3:0] cnt_r;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      cnt_r <= 4'h0;
    else if (i_load)
      cnt_r <= i_count;
    else if (i_tick && cnt_r != 4'h0)
      cnt_r <= cnt_r - 4'h1;
  end

  assign o_done = (cnt_r == 4'h0);

endmodule // wait_counter

// [core/external_bus_cycle_sequencer.sv]
/*
  External bus cycle sequencer: multiplexed and non-multiplexed read and write
  cycles, cycle-time waits and tri-state waits.
  Assumes a CPU that holds a request until acknowledged and an external latch on ALE.
*/
`timescale 1ns/1ns
module external_bus_cycle_sequencer
  import ext_bus_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_CFG_WE,
  input wire system_bus_config_s I_CFG,
  input wire logic I_REQ,
  input wire cpu_req_s I_REQ_INFO,
  input wire logic [DATA_W-1:0] I_AD,
  output logic O_ACK,
  output logic [DATA_W-1:0] O_RDATA,
  output logic O_STALL,
  output logic [DATA_W-1:0] O_AD_OUT,
  output logic O_AD_OE_LO,
  output logic O_AD_OE_HI,
  output logic [DATA_W-1:0] O_ADDR,
  output logic [1:0] O_SEG,
  output logic O_ALE,
  output logic O_RD_N,
  output logic O_WR_N
);

  seq_state_e state_r;
  system_bus_config_s cfg_r;
  system_bus_config_s cfg_cur_r;
  cpu_req_s cur_r;
  logic [1:0] tri_cnt_r;
  logic [1:0] tri_total;
  logic [DATA_W-1:0] ad_meta_r;
  logic [DATA_W-1:0] ad_sync_r;
  logic tick;
  logic wait_done;
  logic take_int;
  logic start_ext;
  logic addr_end;
  logic hold_end;
  logic strobe_end;
  logic enter_strobe;
  logic [4:0] stall_len_r;
  logic [4:0] expect_len;

  half_cycle_tick u_tick (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .o_tick(tick)
  );

  // Inverted field: all ones means no waits
  wait_counter u_wait (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .i_load(enter_strobe),
    .i_count(~cfg_cur_r.cycle_wait_field),
    .i_tick(tick),
    .o_done(wait_done)
  );

  // Requests seen while the ack is out are ignored, so one held request is taken once
  assign take_int = I_REQ && I_REQ_INFO.internal && !O_STALL && !O_ACK;
  assign start_ext = I_REQ && !I_REQ_INFO.internal && (state_r == ST_IDLE) && !O_ACK;
  assign addr_end = (state_r == ST_ADDR) && tick;
  assign hold_end = (state_r == ST_HOLD) && tick;
  assign strobe_end = (state_r == ST_STROBE) && tick && wait_done;
  // Same wait load point for every configuration
  assign enter_strobe = (addr_end && !cfg_cur_r.mux_mode) || hold_end;
  assign tri_total = ((cfg_cur_r.tristate_wait_bit == TRISTATE_INSERT) ? TRI_CNT_ONE : TRI_CNT_ZERO)
    + (cfg_cur_r.mux_mode ? TRI_CNT_ONE : TRI_CNT_ZERO);

  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
      cfg_r <= CFG_RESET;
    else if (I_CFG_WE)
      cfg_r <= I_CFG;
  end

  // Pin data is asynchronous to the clock; data must settle two clocks before capture
  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      ad_meta_r <= 16'h0000;
      ad_sync_r <= 16'h0000;
    end
    else
    begin
      ad_meta_r <= I_AD;
      ad_sync_r <= ad_meta_r;
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      cur_r <= '0;
      cfg_cur_r <= CFG_RESET;
    end
    else if (start_ext)
    begin
      cur_r <= I_REQ_INFO;
      cfg_cur_r <= cfg_r;
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      state_r <= ST_IDLE;
      tri_cnt_r <= TRI_CNT_ZERO;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          if (start_ext)
            state_r <= ST_ADDR;
        end
        ST_ADDR:
        begin
          if (tick)
            state_r <= cfg_cur_r.mux_mode ? ST_HOLD : ST_STROBE;
        end
        ST_HOLD:
        begin
          if (tick)
            state_r <= ST_STROBE;
        end
        ST_STROBE:
        begin
          if (strobe_end)
          begin
            // Next address waits for the memory to release the bus
            if (!cur_r.write && tri_total != TRI_CNT_ZERO)
            begin
              state_r <= ST_TRI;
              tri_cnt_r <= tri_total;
            end
            else
              state_r <= ST_IDLE;
          end
        end
        ST_TRI:
        begin
          if (tick)
          begin
            tri_cnt_r <= tri_cnt_r - TRI_CNT_ONE;
            if (tri_cnt_r == TRI_CNT_ONE)
              state_r <= ST_IDLE;
          end
        end
        default:
        begin
          state_r <= ST_IDLE;
          tri_cnt_r <= TRI_CNT_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      O_AD_OUT <= 16'h0000;
      O_AD_OE_LO <= 1'b0;
      O_AD_OE_HI <= 1'b0;
      O_ADDR <= 16'h0000;
      O_SEG <= 2'h0;
      O_ALE <= 1'b0;
      O_RD_N <= 1'b1;
      O_WR_N <= 1'b1;
    end
    else if (start_ext)
    begin
      O_SEG <= I_REQ_INFO.addr[SEG_HI:SEG_LO];
      if (cfg_r.mux_mode)
      begin
        O_AD_OUT <= I_REQ_INFO.addr[DATA_W-1:0];
        O_AD_OE_LO <= 1'b1;
        O_AD_OE_HI <= 1'b1;
        O_ALE <= 1'b1;
      end
      else
      begin
        O_ADDR <= I_REQ_INFO.addr[DATA_W-1:0];
        O_AD_OE_LO <= 1'b0;
        O_AD_OE_HI <= 1'b0;
      end
    end
    else if (addr_end)
    begin
      if (cfg_cur_r.mux_mode)
        O_ALE <= 1'b0;
      else if (cur_r.write)
      begin
        O_AD_OUT <= cur_r.wdata;
        O_AD_OE_LO <= 1'b1;
        O_AD_OE_HI <= 1'b1;
        O_WR_N <= 1'b0;
      end
      else
        O_RD_N <= 1'b0;
    end
    else if (hold_end)
    begin
      if (cur_r.write)
      begin
        if (cfg_cur_r.byte_mode)
          O_AD_OUT[LANE_LO_MSB:0] <= cur_r.wdata[LANE_LO_MSB:0];
        else
          O_AD_OUT <= cur_r.wdata;
        O_WR_N <= 1'b0;
      end
      else
      begin
        O_AD_OE_LO <= 1'b0;
        O_AD_OE_HI <= cfg_cur_r.byte_mode;
        O_RD_N <= 1'b0;
      end
    end
    else if (strobe_end)
    begin
      // Drive enables stay as they are: written data is held until the next start
      O_RD_N <= 1'b1;
      O_WR_N <= 1'b1;
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      O_ACK <= 1'b0;
      O_RDATA <= 16'h0000;
    end
    else
    begin
      O_ACK <= take_int || strobe_end;
      if (strobe_end && !cur_r.write)
      begin
        if (cfg_cur_r.mux_mode && cfg_cur_r.byte_mode)
          O_RDATA <= {8'h00, ad_sync_r[LANE_LO_MSB:0]};
        else
          O_RDATA <= ad_sync_r;
      end
    end
  end

  // Stall covers address, hold and strobe phases only, never the tri-state wait
  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
      O_STALL <= 1'b0;
    else if (start_ext)
      O_STALL <= 1'b1;
    else if (strobe_end)
      O_STALL <= 1'b0;
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
      stall_len_r <= 5'h00;
    else if (start_ext)
      stall_len_r <= 5'h00;
    else if (O_STALL)
      stall_len_r <= stall_len_r + 5'h01;
  end

  assign expect_len = (cfg_cur_r.mux_mode ? MUX_BASE_HALVES : NONMUX_BASE_HALVES)
    + {1'b0, ~cfg_cur_r.cycle_wait_field};

  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_RST);

  sequence s_mux_zero_start;
    $rose(O_STALL) && cfg_cur_r.mux_mode && (cfg_cur_r.cycle_wait_field == WAIT_FIELD_NONE)
      && (HALF_CYCLE_CLKS == 1);
  endsequence

  sequence s_nonmux_zero_start;
    $rose(O_STALL) && !cfg_cur_r.mux_mode && (cfg_cur_r.cycle_wait_field == WAIT_FIELD_NONE)
      && (HALF_CYCLE_CLKS == 1);
  endsequence

  sequence s_mux_phases;
    O_ALE ##1 (!O_ALE && O_AD_OE_LO) ##1 (!O_RD_N || !O_WR_N) ##1 (O_ACK && O_RD_N && O_WR_N);
  endsequence

  a_ale_with_addr: assert property ($rose(O_ALE) |-> O_AD_OE_LO && O_AD_OE_HI ##1 !O_ALE && O_AD_OE_LO)
    else $error("address not held around latch strobe");

  a_byte_high_lane: assert property (O_STALL && cfg_cur_r.mux_mode && cfg_cur_r.byte_mode
    |-> O_AD_OE_HI && (O_AD_OUT[LANE_HI_MSB:LANE_HI_LSB] == cur_r.addr[LANE_HI_MSB:LANE_HI_LSB]))
    else $error("upper lane lost address in byte mode");

  a_seg_driven: assert property (O_STALL |-> O_SEG == cur_r.addr[SEG_HI:SEG_LO])
    else $error("segment address changed during access");

  a_read_release: assert property ($fell(O_RD_N) && cfg_cur_r.mux_mode |-> !O_AD_OE_LO)
    else $error("bus still driven when read strobe fell");

  a_read_capture: assert property ($rose(O_RD_N) && !cfg_cur_r.byte_mode |-> O_ACK && O_RDATA == $past(ad_sync_r))
    else $error("read data not captured at strobe end");

  a_write_hold: assert property ($rose(O_WR_N) |-> O_AD_OE_LO && $stable(O_AD_OUT))
    else $error("write data dropped at strobe end");

  a_mux_zero_wait: assert property (s_mux_zero_start |-> s_mux_phases)
    else $error("multiplexed zero wait cycle not three half cycles");

  a_nonmux_zero_wait: assert property (s_nonmux_zero_start |-> ##1 (!O_RD_N || !O_WR_N) ##1 O_ACK)
    else $error("non-multiplexed zero wait cycle not two half cycles");

  a_wait_length: assert property (O_ACK && $past(O_STALL) && (HALF_CYCLE_CLKS == 1)
    |-> stall_len_r == expect_len)
    else $error("stall length does not match programmed waits");

  a_tri_no_stall: assert property (state_r == ST_TRI |-> !O_STALL && O_RD_N && !O_AD_OE_LO)
    else $error("stall or drive during tri-state wait");

  a_internal_fast: assert property (take_int |=> O_ACK && !O_STALL && O_RD_N && O_WR_N)
    else $error("internal access touched external bus");

endmodule // external_bus_cycle_sequencer

// [testbench/ext_mem_model.sv]
/*
  External asynchronous memory with its address latch.
  Assumes strobes and drive enables come straight from the sequencer.
*/
`timescale 1ns/1ns
module ext_mem_model
(
  input wire logic clk,
  input wire logic mux,
  input wire logic ale,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic oe_lo,
  input wire logic oe_hi,
  input wire logic [15:0] ad_out,
  input wire logic [15:0] addr,
  output logic [15:0] ad
);
  logic [15:0] mem [16];
  logic [15:0] lat = 16'h0000;
  logic [15:0] last = 16'h0000;
  logic drv = 1'b0;
  logic [3:0] idx;
  logic [15:0] rd_v;
  assign idx = mux ? lat[3:0] : addr[3:0];
  // Transparent while the strobe is high
  always @(*) if (ale) lat = ad_out;
  // Slow part: data lags the strobe, so short waits read garbage
  always @(rd_n) drv <= #30 !rd_n;
  always @(posedge wr_n) mem[idx] = ad;
  // Released lanes toggle so a stale value never passes
  always @(posedge clk) last <= ad;
  assign rd_v = drv ? mem[idx] : ~last;
  assign ad[7:0] = oe_lo ? ad_out[7:0] : rd_v[7:0];
  assign ad[15:8] = oe_hi ? ad_out[15:8] : rd_v[15:8];
endmodule // ext_mem_model

// [testbench/external_bus_cycle_sequencer_tb_top.sv]
/*
  Self-checking bench for the external bus cycle sequencer.
  Assumes the memory model on the pins and inputs driven at falling edges.
*/
`timescale 1ns/1ns
module external_bus_cycle_sequencer_tb_top
  import ext_bus_pkg::*;
;
  logic I_CLK = 1'b0;
  logic I_RST = 1'b1;
  logic I_CFG_WE = 1'b0;
  system_bus_config_s I_CFG = CFG_RESET;
  logic I_REQ = 1'b0;
  cpu_req_s I_REQ_INFO = '0;
  logic [15:0] ad;
  logic O_ACK, O_STALL, O_AD_OE_LO, O_AD_OE_HI, O_ALE, O_RD_N, O_WR_N;
  logic [15:0] O_RDATA, O_AD_OUT, O_ADDR;
  logic [1:0] O_SEG;
  logic [1:0] tri_n = 2'h0;
  logic [15:0] rd;
  int num_errors = 0;
  int n_tests = 0;

  external_bus_cycle_sequencer i_dut (.I_CLK(I_CLK), .I_RST(I_RST), .I_CFG_WE(I_CFG_WE),
    .I_CFG(I_CFG), .I_REQ(I_REQ), .I_REQ_INFO(I_REQ_INFO), .I_AD(ad), .O_ACK(O_ACK),
    .O_RDATA(O_RDATA), .O_STALL(O_STALL), .O_AD_OUT(O_AD_OUT), .O_AD_OE_LO(O_AD_OE_LO),
    .O_AD_OE_HI(O_AD_OE_HI), .O_ADDR(O_ADDR), .O_SEG(O_SEG), .O_ALE(O_ALE),
    .O_RD_N(O_RD_N), .O_WR_N(O_WR_N));
  ext_mem_model i_mem (.clk(I_CLK), .mux(I_CFG.mux_mode), .ale(O_ALE), .rd_n(O_RD_N),
    .wr_n(O_WR_N), .oe_lo(O_AD_OE_LO), .oe_hi(O_AD_OE_HI), .ad_out(O_AD_OUT),
    .addr(O_ADDR), .ad(ad));

  initial
  begin
    forever #50 I_CLK = ~I_CLK;
  end

  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Gap long enough for any tri-state wait to run out
  task automatic gap();
    @(negedge I_CLK);
    I_REQ = 1'b0;
    repeat (3) @(negedge I_CLK);
    tri_n = 2'h0;
  endtask

  task automatic set_cfg(input logic m, input logic b, input logic t, input logic [3:0] f);
    @(negedge I_CLK);
    I_REQ = 1'b0;
    I_CFG = '{m, b, t, f};
    I_CFG_WE = 1'b1;
    @(negedge I_CLK);
    I_CFG_WE = 1'b0;
    gap();
  endtask

  // One access; request stays up after ack so a following call runs back to back
  task automatic acc(input logic w, input logic i, input logic [17:0] a, input logic [15:0] d,
    output logic [15:0] r);
    int n, ale_n, st_n, sb_n, base, wt;
    // Internal access acks in the cycle right after the take edge
    base = i ? 0 : (I_CFG.mux_mode ? 3 : 2);
    wt = i ? 0 : 15 - int'(I_CFG.cycle_wait_field);
    n = 0;
    ale_n = 0;
    st_n = 0;
    sb_n = 0;
    @(negedge I_CLK);
    I_REQ = 1'b1;
    I_REQ_INFO = '{w, i, a, d};
    while (n == 0 || (n < 40 && O_ACK !== 1'b1))
    begin
      @(posedge I_CLK);
      #1;
      n++;
      ale_n += int'(O_ALE === 1'b1);
      sb_n += int'(O_RD_N === 1'b0 || O_WR_N === 1'b0);
      if (O_STALL === 1'b1)
      begin
        st_n++;
        chk(O_SEG, a[17:16]);
        if (I_CFG.mux_mode && I_CFG.byte_mode)
          chk({O_AD_OE_HI, O_AD_OUT[15:8]}, {1'b1, a[15:8]});
        if (O_ALE === 1'b1)
          chk({O_AD_OE_LO, O_AD_OUT}, {1'b1, a[15:0]});
        if (O_RD_N === 1'b0 && I_CFG.mux_mode)
          chk(O_AD_OE_LO, 1'b0);
      end
    end
    if (O_ACK !== 1'b1)
    begin
      num_errors++;
      give_verdict();
    end
    else
    begin
      chk(18'(n), 18'(1 + int'(tri_n) + base + wt));
      chk(18'(st_n), i ? 18'h0 : 18'(base + wt));
      chk({O_STALL, 2'(ale_n), 5'(sb_n)}, {1'b0, 2'(!i && I_CFG.mux_mode), i ? 5'h0 : 5'(1 + wt)});
      r = O_RDATA;
      // A held request loses the edge of the ack cycle; a read's first tri-state wait overlaps that edge, a second one adds an edge
      tri_n = 2'h1 + 2'(!w && !i && I_CFG.mux_mode && !I_CFG.tristate_wait_bit);
    end
  endtask

  task automatic t_reset();
    chk({O_ACK, O_STALL, O_AD_OE_LO, O_AD_OE_HI, O_ALE, O_RD_N, O_WR_N, O_SEG}, 9'h00C);
    chk(O_AD_OUT | O_ADDR | O_RDATA, 16'h0000);
    acc(1'b1, 1'b0, 18'h1_0004, 16'hBEEF, rd);
    acc(1'b0, 1'b0, 18'h1_0004, 16'h0000, rd);
    chk(rd, 16'hBEEF);
    gap();
  endtask

  task automatic t_mux_word();
    set_cfg(1'b1, 1'b0, 1'b1, 4'hC);
    acc(1'b1, 1'b0, 18'h3_0001, 16'h1234, rd);
    acc(1'b1, 1'b0, 18'h0_0002, 16'h5678, rd);
    gap();
    chk({O_AD_OE_LO, O_AD_OUT}, {1'b1, 16'h5678});
    acc(1'b0, 1'b0, 18'h3_0001, 16'h0000, rd);
    chk(rd, 16'h1234);
    acc(1'b0, 1'b0, 18'h0_0002, 16'h0000, rd);
    chk(rd, 16'h5678);
    gap();
  endtask

  task automatic t_tri_insert();
    set_cfg(1'b1, 1'b0, 1'b0, 4'hC);
    acc(1'b0, 1'b0, 18'h3_0001, 16'h0000, rd);
    chk(rd, 16'h1234);
    acc(1'b0, 1'b0, 18'h0_0002, 16'h0000, rd);
    chk(rd, 16'h5678);
    gap();
  endtask

  // Zero waits leave the pin synchroniser too little time, so the data is judged on a slow read
  task automatic t_mux_fast();
    set_cfg(1'b1, 1'b0, 1'b1, 4'hF);
    acc(1'b1, 1'b0, 18'h2_000A, 16'h0F0F, rd);
    acc(1'b0, 1'b0, 18'h2_000A, 16'h0000, rd);
    gap();
    set_cfg(1'b1, 1'b0, 1'b1, 4'hC);
    acc(1'b0, 1'b0, 18'h2_000A, 16'h0000, rd);
    chk(rd, 16'h0F0F);
    gap();
  endtask

  task automatic t_byte();
    set_cfg(1'b1, 1'b1, 1'b1, 4'hD);
    acc(1'b1, 1'b0, 18'h2_AB05, 16'h00C6, rd);
    acc(1'b0, 1'b0, 18'h2_AB05, 16'h0000, rd);
    chk(rd, 16'h00C6);
    gap();
  endtask

  task automatic t_nonmux();
    set_cfg(1'b0, 1'b0, 1'b1, 4'hF);
    acc(1'b1, 1'b0, 18'h1_0007, 16'h9A9A, rd);
    gap();
    chk({O_ADDR, O_AD_OE_LO, O_AD_OE_HI}, {16'h0007, 2'b11});
    chk(O_AD_OUT, 16'h9A9A);
    set_cfg(1'b0, 1'b0, 1'b0, 4'hC);
    acc(1'b0, 1'b0, 18'h1_0007, 16'h0000, rd);
    acc(1'b0, 1'b0, 18'h1_0007, 16'h0000, rd);
    chk(rd, 16'h9A9A);
    gap();
  endtask

  task automatic t_internal();
    acc(1'b0, 1'b1, 18'h0_0003, 16'h0000, rd);
    gap();
  endtask

  initial
  begin
    repeat (12) @(negedge I_CLK);
    I_RST = 1'b0;
    t_reset();
    t_mux_word();
    t_tri_insert();
    t_byte();
    t_mux_fast();
    t_nonmux();
    t_internal();
    give_verdict();
  end
endmodule // external_bus_cycle_sequencer_tb_top
